// *** ddsh_pkg.sv ***
// Shared constants and types for the disk status and seek handshake link.
`default_nettype none
package ddsh_pkg;
    // Clock of both ends.
    localparam int CLK_PERIOD_NS = 40;
    // Seek answer: delay from strobe and width of the answer pulse; width of the fault pulse.
    localparam int SEEK_DELAY_NS = 30000;
    localparam int SEEK_PULSE_NS = 5000;
    localparam int FAULT_PULSE_NS = 5000;
    localparam int CNT_W = 10;
    typedef logic [CNT_W-1:0] ddsh_cnt_t;
    localparam ddsh_cnt_t SEEK_DELAY_CYC =
        ddsh_cnt_t'(SEEK_DELAY_NS / CLK_PERIOD_NS);
    localparam ddsh_cnt_t SEEK_PULSE_CYC =
        ddsh_cnt_t'(SEEK_PULSE_NS / CLK_PERIOD_NS);
    localparam ddsh_cnt_t FAULT_PULSE_CYC =
        ddsh_cnt_t'(FAULT_PULSE_NS / CLK_PERIOD_NS);
    // Bit cell of the read path, in clock cycles.
    typedef logic [2:0] ddsh_cell_t;
    localparam ddsh_cell_t CELL_LAST = 3'h7;
    localparam ddsh_cell_t RCLK_LOW_CYC = 3'h2;
    localparam ddsh_cell_t DATA_ON = 3'h3;
    localparam ddsh_cell_t DATA_OFF = 3'h6;
    // Cylinder address.
    localparam int CYL_W = 8;
    localparam logic [CYL_W-1:0] MAX_CYL = 8'hc7;
    // Controller register byte offsets.
    localparam logic [7:0] REG_SEEK = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0c;
    localparam logic [7:0] REG_LINE = 8'h10;
    localparam logic [7:0] REG_RXD = 8'h14;
    // Control field positions and width.
    localparam int CTRL_W = 5;
    localparam int CTRL_SEL = 0;
    localparam int CTRL_PLAT = 1;
    localparam int CTRL_RGATE = 2;
    localparam int CTRL_WGATE = 3;
    localparam int CTRL_EGATE = 4;
    // Status and mask field positions and width.
    localparam int ST_W = 4;
    localparam int ST_ACC = 0;
    localparam int ST_ILL = 1;
    localparam int ST_FLT = 2;
    localparam int ST_RX = 3;
    // Line status field positions.
    localparam int LINE_W = 6;
    localparam int LINE_WOK = 0;
    localparam int LINE_DUAL = 1;
    localparam int LINE_HD = 2;
    localparam int LINE_BUSY = 3;
    localparam int LINE_POSF = 4;
    localparam int LINE_NRDY = 5;
    typedef enum logic [3:0] {
        SK_IDLE = 4'h1,
        SK_WAIT = 4'h2,
        SK_PULSE = 4'h4,
        SK_HOLD = 4'h8
    } ddsh_seek_e;
    typedef enum logic [2:0] {
        HS_IDLE = 3'h1,
        HS_SETUP = 3'h2,
        HS_STROBE = 3'h4
    } ddsh_hseek_e;
endpackage
`default_nettype wire

// *** ddsh_if.sv ***
// Interface lines between the drive and its controller; all are low-true.
`default_nettype none
interface ddsh_if;
    // Controller to drive.
    logic select_n;
    logic plat_sel_n;
    logic strobe_n;
    logic [ddsh_pkg::CYL_W-1:0] cyl_n;
    logic read_gate_n;
    logic write_gate_n;
    logic erase_gate_n;
    // Drive to controller.
    logic read_clock_n;
    logic read_data_n;
    logic seek_accept_pulse_n;
    logic illegal_seek_pulse_n;
    logic wr_status_n;
    logic fault_n;
    logic unused_positioner_fail_line_n;
    logic high_density_n;
    logic dual_platter_n;
    modport drive (
        input select_n, plat_sel_n, strobe_n, cyl_n,
        input read_gate_n, write_gate_n, erase_gate_n,
        output read_clock_n, read_data_n, seek_accept_pulse_n,
        output illegal_seek_pulse_n, wr_status_n, fault_n,
        output unused_positioner_fail_line_n, high_density_n,
        output dual_platter_n
    );
    modport ctl (
        output select_n, plat_sel_n, strobe_n, cyl_n,
        output read_gate_n, write_gate_n, erase_gate_n,
        input read_clock_n, read_data_n, seek_accept_pulse_n,
        input illegal_seek_pulse_n, wr_status_n, fault_n,
        input unused_positioner_fail_line_n, high_density_n,
        input dual_platter_n
    );
endinterface
`default_nettype wire

// *** ddsh_sync.sv ***
// Two-stage synchroniser for a group of levels from another domain.
`default_nettype none
module ddsh_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// *** ddsh_drive.sv ***
// Drive end: read path, seek answer, write status, fault and strap lines.
`default_nettype none
// Summary of operation
// - Timing line pulses low at each cell start.
// - Timing line returns high until next cell.
// - Data line pulses low for ones only.
// - Controller decodes one from data low, clock high.
// - Accept pulse 2.5-7.5us, 22.5-37.5us after strobe.
// - Legal seeks accepted, illegal ones flagged instead.
// - Controller holds address and strobe until answer.
// - Illegal seek: no move, illegal pulse timed alike.
// - Controller drops strobe within 5us of answer.
// - Protected platter: write and erase refused.
// - Write status follows platter select within 1us.
// - Controller checks write status before writing.
// - Fault line pulses low on any fault.
// - Any fault starts emergency head unload.
// - Seek-failure line stays high; positioner faults unload.
// - Density line steady true when fitted.
// - Platter count line valid while selected.
// - Every link line is low-true.
module ddsh_drive (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Link to the controller
    ddsh_if.drive LINK,
    // Recovered disk bit stream
    input wire logic DISK_BIT,
    output logic DISK_BIT_TAKE,
    // Fault detectors and factory straps
    input wire logic FAULT_WRITE,
    input wire logic FAULT_SERVO,
    input wire logic FAULT_SPEED,
    input wire logic FAULT_POWER,
    input wire logic [1:0] PROTECT_PLATTER,
    input wire logic HIGH_DENSITY_FITTED,
    input wire logic DUAL_PLATTER_FITTED,
    // Mechanism commands and status
    output logic SEEK_START,
    output logic [ddsh_pkg::CYL_W-1:0] SEEK_CYL,
    output logic HEAD_UNLOAD,
    output logic NOT_READY,
    output logic WRITE_ON,
    output logic ERASE_ON
);
    import ddsh_pkg::*;

    localparam int HOST_W = CYL_W + 6;
    localparam int LOC_W = 8;

    logic [HOST_W-1:0] host_raw;
    logic [HOST_W-1:0] host_s;
    logic [LOC_W-1:0] loc_raw;
    logic [LOC_W-1:0] loc_s;
    logic sel_n, plat_n, strobe_n, rgate_n, wgate_n, egate_n;
    logic [CYL_W-1:0] cyl_n;
    logic [3:0] fault_s;
    logic [1:0] prot_s;
    logic hd_s, dual_s;
    logic sel, strobe, reading, platter_ok;
    logic strobe_prev;
    ddsh_seek_e seek_state;
    ddsh_cnt_t seek_cnt;
    logic cyl_legal;
    logic [CYL_W-1:0] cyl_req;
    ddsh_cell_t cell_cnt;
    logic cell_bit;
    logic fault_any, fault_prev;
    ddsh_cnt_t fault_cnt;

    // Every line from the controller and every local detector is
    // asynchronous to this clock.
    assign host_raw = {LINK.select_n, LINK.plat_sel_n, LINK.strobe_n,
        LINK.read_gate_n, LINK.write_gate_n, LINK.erase_gate_n,
        LINK.cyl_n};
    assign loc_raw = {FAULT_WRITE, FAULT_SERVO, FAULT_SPEED, FAULT_POWER,
        PROTECT_PLATTER, HIGH_DENSITY_FITTED, DUAL_PLATTER_FITTED};

    ddsh_sync #(
        .W(HOST_W),
        .INIT({HOST_W{1'b1}})
    ) u_host_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .d(host_raw),
        .q(host_s)
    );

    ddsh_sync #(
        .W(LOC_W),
        .INIT({LOC_W{1'b0}})
    ) u_loc_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .d(loc_raw),
        .q(loc_s)
    );

    assign {sel_n, plat_n, strobe_n, rgate_n, wgate_n, egate_n, cyl_n} =
        host_s;
    assign {fault_s, prot_s, hd_s, dual_s} = loc_s;

    // Low level is the true state on every link line.
    assign sel = !sel_n;
    assign strobe = !strobe_n;
    assign reading = sel && !rgate_n;
    assign platter_ok = !prot_s[!plat_n];
    assign fault_any = |fault_s;

    // Seek handshake sequencer.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            seek_state <= SK_IDLE;
            seek_cnt <= '0;
            strobe_prev <= 1'b0;
        end else begin
            strobe_prev <= strobe;
            unique case (seek_state)
                SK_IDLE: begin
                    // Only a fresh leading edge starts a seek.
                    if (strobe && !strobe_prev) begin
                        seek_state <= SK_WAIT;
                        seek_cnt <= '0;
                    end
                end
                SK_WAIT: begin
                    if (seek_cnt == SEEK_DELAY_CYC - 1'b1) begin
                        seek_state <= SK_PULSE;
                        seek_cnt <= '0;
                    end else begin
                        seek_cnt <= seek_cnt + 1'b1;
                    end
                end
                SK_PULSE: begin
                    if (seek_cnt == SEEK_PULSE_CYC - 1'b1) begin
                        seek_state <= SK_HOLD;
                    end else begin
                        seek_cnt <= seek_cnt + 1'b1;
                    end
                end
                SK_HOLD: begin
                    if (!strobe) begin
                        seek_state <= SK_IDLE;
                    end
                end
            endcase
        end
    end

    // The address is taken late, when it has long settled; the controller
    // keeps it steady until the answer, so bit skew through the
    // synchronisers cannot tear it.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cyl_req <= '0;
            cyl_legal <= 1'b0;
        end else if (seek_state == SK_WAIT &&
                     seek_cnt == SEEK_DELAY_CYC - 1'b1) begin
            cyl_req <= ~cyl_n;
            cyl_legal <= (~cyl_n) <= MAX_CYL;
        end
    end

    // Answer pulses; an illegal seek never reaches the mechanism.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            LINK.seek_accept_pulse_n <= 1'b1;
            LINK.illegal_seek_pulse_n <= 1'b1;
            SEEK_START <= 1'b0;
            SEEK_CYL <= '0;
        end else begin
            LINK.seek_accept_pulse_n <=
                !(seek_state == SK_PULSE && cyl_legal);
            LINK.illegal_seek_pulse_n <=
                !(seek_state == SK_PULSE && !cyl_legal);
            SEEK_START <= seek_state == SK_PULSE && seek_cnt == '0 &&
                cyl_legal;
            if (seek_state == SK_PULSE && seek_cnt == '0 && cyl_legal) begin
                SEEK_CYL <= cyl_req;
            end
        end
    end

    // Bit cell counter of the read path.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cell_cnt <= '0;
            cell_bit <= 1'b0;
            DISK_BIT_TAKE <= 1'b0;
        end else begin
            if (!reading || cell_cnt == CELL_LAST) begin
                cell_cnt <= '0;
            end else begin
                cell_cnt <= cell_cnt + 1'b1;
            end
            DISK_BIT_TAKE <= reading && cell_cnt == '0;
            if (reading && cell_cnt == '0) begin
                cell_bit <= DISK_BIT;
            end
        end
    end

    // The data pulse sits wholly inside the high part of the clock so the
    // controller sees it between two clock pulses.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            LINK.read_clock_n <= 1'b1;
            LINK.read_data_n <= 1'b1;
        end else begin
            LINK.read_clock_n <= !(reading &&
                cell_cnt < RCLK_LOW_CYC);
            LINK.read_data_n <= !(reading && cell_bit &&
                cell_cnt >= DATA_ON && cell_cnt < DATA_OFF);
        end
    end

    // Write status and refusal of write and erase on a protected platter.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            LINK.wr_status_n <= 1'b1;
            WRITE_ON <= 1'b0;
            ERASE_ON <= 1'b0;
        end else begin
            LINK.wr_status_n <= !(sel && !platter_ok);
            WRITE_ON <= sel && !wgate_n && platter_ok && !NOT_READY;
            ERASE_ON <= sel && !egate_n && platter_ok && !NOT_READY;
        end
    end

    // Fault pulse, emergency unload and loss of ready.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            fault_prev <= 1'b0;
            fault_cnt <= '0;
            LINK.fault_n <= 1'b1;
            HEAD_UNLOAD <= 1'b0;
            NOT_READY <= 1'b0;
        end else begin
            fault_prev <= fault_any;
            if (fault_any && !fault_prev) begin
                fault_cnt <= FAULT_PULSE_CYC;
            end else if (fault_cnt != '0) begin
                fault_cnt <= fault_cnt - 1'b1;
            end
            LINK.fault_n <= fault_cnt == '0;
            HEAD_UNLOAD <= fault_any && !fault_prev;
            // Ready is only restored by a reset of the drive logic.
            if (fault_any) begin
                NOT_READY <= 1'b1;
            end
        end
    end

    // Strap and capability lines.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            LINK.unused_positioner_fail_line_n <= 1'b1;
            LINK.high_density_n <= 1'b1;
            LINK.dual_platter_n <= 1'b1;
        end else begin
            LINK.unused_positioner_fail_line_n <= 1'b1;
            LINK.high_density_n <= !hd_s;
            LINK.dual_platter_n <= !(sel && dual_s);
        end
    end
endmodule
`default_nettype wire

// *** ddsh_ctl.sv ***
// Controller end: AHB-Lite registers, seek strobe, read decode, interrupt.
`default_nettype none
module ddsh_ctl (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Interrupt
    output logic IRQ,
    // Link to the drive
    ddsh_if.ctl LINK
);
    import ddsh_pkg::*;

    localparam int IN_W = 9;

    logic [IN_W-1:0] in_raw;
    logic [IN_W-1:0] in_s;
    logic rclk, rdat, acc, ill, wok, flt, hd, dual, posf;
    logic rclk_prev, acc_prev, ill_prev, flt_prev;
    logic [7:0] ap_addr;
    logic wr_pend, rd_pend;
    logic [CTRL_W-1:0] ctrl;
    logic [ST_W-1:0] stat, mask, stat_set, stat_clr;
    logic [7:0] rx_shift, rx_byte;
    logic [2:0] bit_cnt;
    logic have_cell, one_seen, rx_done;
    ddsh_hseek_e hs_state;
    logic seek_go;

    assign in_raw = {LINK.read_clock_n, LINK.read_data_n,
        LINK.seek_accept_pulse_n, LINK.illegal_seek_pulse_n,
        LINK.wr_status_n, LINK.fault_n, LINK.high_density_n,
        LINK.dual_platter_n, LINK.unused_positioner_fail_line_n};

    ddsh_sync #(
        .W(IN_W),
        .INIT({IN_W{1'b1}})
    ) u_in_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .d(in_raw),
        .q(in_s)
    );

    // Low level is the true state of every line.
    assign {rclk, rdat, acc, ill, wok, flt, hd, dual, posf} = ~in_s;

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        unique case (a)
            REG_CTRL: r[CTRL_W-1:0] = ctrl;
            REG_STAT: r[ST_W-1:0] = stat;
            REG_MASK: r[ST_W-1:0] = mask;
            REG_LINE: begin
                r[LINE_WOK] = !wok;
                r[LINE_DUAL] = dual;
                r[LINE_HD] = hd;
                r[LINE_BUSY] = hs_state != HS_IDLE;
                r[LINE_POSF] = posf;
                r[LINE_NRDY] = stat[ST_FLT];
            end
            REG_RXD: r[7:0] = rx_byte;
            default: r = '0;
        endcase
        return r;
    endfunction

    // Writes finish with no wait; reads take one wait state so that the
    // read data leave a flip-flop.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ap_addr <= '0;
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            HREADYOUT <= 1'b1;
            HRDATA <= '0;
            HRESP <= 1'b0;
        end else begin
            wr_pend <= 1'b0;
            if (rd_pend) begin
                HRDATA <= reg_read(ap_addr);
                HREADYOUT <= 1'b1;
                rd_pend <= 1'b0;
            end else if (HSEL && HTRANS[1] && HREADY) begin
                ap_addr <= HADDR[7:0];
                wr_pend <= HWRITE;
                rd_pend <= !HWRITE;
                HREADYOUT <= HWRITE;
            end
        end
    end

    assign seek_go = wr_pend && ap_addr == REG_SEEK && hs_state == HS_IDLE;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctrl <= '0;
            mask <= '0;
        end else if (wr_pend) begin
            if (ap_addr == REG_CTRL) begin
                ctrl <= HWDATA[CTRL_W-1:0];
            end
            if (ap_addr == REG_MASK) begin
                mask <= HWDATA[ST_W-1:0];
            end
        end
    end

    // Seek strobe: address first, strobe a cycle later, both held until
    // either answer is seen.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            hs_state <= HS_IDLE;
            LINK.strobe_n <= 1'b1;
            LINK.cyl_n <= '1;
        end else begin
            unique case (hs_state)
                HS_IDLE: begin
                    if (seek_go) begin
                        LINK.cyl_n <= ~HWDATA[CYL_W-1:0];
                        hs_state <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    LINK.strobe_n <= 1'b0;
                    hs_state <= HS_STROBE;
                end
                HS_STROBE: begin
                    if (acc || ill) begin
                        LINK.strobe_n <= 1'b1;
                        hs_state <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    // Gates; a write or erase starts only on a writable platter.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            LINK.select_n <= 1'b1;
            LINK.plat_sel_n <= 1'b1;
            LINK.read_gate_n <= 1'b1;
            LINK.write_gate_n <= 1'b1;
            LINK.erase_gate_n <= 1'b1;
        end else begin
            LINK.select_n <= !ctrl[CTRL_SEL];
            LINK.plat_sel_n <= !ctrl[CTRL_PLAT];
            LINK.read_gate_n <= !ctrl[CTRL_RGATE];
            LINK.write_gate_n <= !(ctrl[CTRL_WGATE] && !wok);
            LINK.erase_gate_n <= !(ctrl[CTRL_EGATE] && !wok);
        end
    end

    // Read decode: a one is any data pulse seen while the clock line is
    // high within a cell; the bit is settled at the next clock pulse.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rclk_prev <= 1'b0;
            have_cell <= 1'b0;
            one_seen <= 1'b0;
            bit_cnt <= '0;
            rx_shift <= '0;
            rx_byte <= '0;
            rx_done <= 1'b0;
        end else begin
            rclk_prev <= rclk;
            rx_done <= 1'b0;
            if (!ctrl[CTRL_RGATE]) begin
                have_cell <= 1'b0;
                one_seen <= 1'b0;
                bit_cnt <= '0;
            end else if (rclk && !rclk_prev) begin
                have_cell <= 1'b1;
                one_seen <= 1'b0;
                if (have_cell) begin
                    rx_shift <= {rx_shift[6:0], one_seen};
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == 3'h7) begin
                        rx_byte <= {rx_shift[6:0], one_seen};
                        rx_done <= 1'b1;
                    end
                end
            end else if (rdat && !rclk) begin
                one_seen <= 1'b1;
            end
        end
    end

    always_comb begin
        stat_set = '0;
        stat_set[ST_ACC] = acc && !acc_prev;
        stat_set[ST_ILL] = ill && !ill_prev;
        stat_set[ST_FLT] = flt && !flt_prev;
        stat_set[ST_RX] = rx_done;
        stat_clr = '0;
        if (wr_pend && ap_addr == REG_STAT) begin
            stat_clr = HWDATA[ST_W-1:0];
        end
    end

    // A new event outranks a clear in the same cycle.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            acc_prev <= 1'b0;
            ill_prev <= 1'b0;
            flt_prev <= 1'b0;
            stat <= '0;
            IRQ <= 1'b0;
        end else begin
            acc_prev <= acc;
            ill_prev <= ill;
            flt_prev <= flt;
            stat <= (stat & ~stat_clr) | stat_set;
            IRQ <= |(stat & mask);
        end
    end
endmodule
`default_nettype wire

// *** ddsh_assertions.sv ***
// Checker of the timing on the drive and controller link.
`default_nettype none
module ddsh_assertions
    import ddsh_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Link lines
    input wire logic strobe_n,
    input wire logic [CYL_W-1:0] cyl_n,
    input wire logic read_clock_n,
    input wire logic read_data_n,
    input wire logic seek_accept_pulse_n,
    input wire logic illegal_seek_pulse_n,
    input wire logic fault_n,
    input wire logic unused_positioner_fail_line_n
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    wire ans_n = seek_accept_pulse_n & illegal_seek_pulse_n;
    logic [7:0] wid;
    logic [9:0] since;
    // Saturating, so that an over-long answer pulse still fails the width check.
    always_ff @(posedge CLK) begin
        if (!RESET_N || ans_n) wid <= 8'h00;
        else if (wid != 8'hff) wid <= wid + 8'h01;
    end
    always_ff @(posedge CLK) begin
        if (!RESET_N || $fell(strobe_n)) since <= 10'h000;
        else if (since != 10'h3ff) since <= since + 10'h001;
    end
    sequence s_clk_pulse; !read_clock_n ##1 read_clock_n; endsequence
    property p_clk_low; $fell(read_clock_n) |=> s_clk_pulse; endproperty
    a_clk_low: assert property (p_clk_low) else $error("clock low");
    property p_clk_high; $rose(read_clock_n) |-> read_clock_n [*6]; endproperty
    a_clk_high: assert property (p_clk_high) else $error("cell short");
    property p_data; !read_data_n |-> read_clock_n; endproperty
    a_data: assert property (p_data) else $error("data during clock");
    property p_ans_time; $fell(ans_n) |-> since inside {[563:937]}; endproperty
    a_ans_time: assert property (p_ans_time) else $error("delay");
    property p_ans_wid; $rose(ans_n) |-> wid inside {[63:187]}; endproperty
    a_ans_wid: assert property (p_ans_wid) else $error("width");
    property p_acc; $fell(seek_accept_pulse_n) |-> ~cyl_n<=MAX_CYL; endproperty
    a_acc: assert property (p_acc) else $error("bad accept");
    property p_ill; $fell(illegal_seek_pulse_n) |-> ~cyl_n>MAX_CYL; endproperty
    a_ill: assert property (p_ill) else $error("illegal flag wrong");
    property p_fault; $fell(fault_n) |-> !fault_n [*8]; endproperty
    a_fault: assert property (p_fault) else $error("fault pulse short");
    property p_unused; unused_positioner_fail_line_n; endproperty
    a_unused: assert property (p_unused) else $error("unused line low");
endmodule
`default_nettype wire

// *** ddsh_bench.sv ***
// Bench joining the drive end and the controller end over one link.
`default_nettype none
module ddsh_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ddsh_pkg::*;
    localparam logic [7:0] PAT = 8'hb4;
    logic CLK = 0, RESET_N = 0, hw = 0, irq, sk, unl, nrdy, won, eon, tk = 0;
    logic [1:0] htrans = 2'h0, prot = 2'h1;
    logic [3:0] flt = 4'h0;
    logic [2:0] bi = 3'h7;
    logic [7:0] cyl;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    wire hready, hresp, tk_raw;
    int error_cnt = 0, checks = 0, n_seek = 0, n_unl = 0;
    ddsh_if link();
    ddsh_drive ddsh_drive_inst (.CLK(CLK), .RESET_N(RESET_N), .LINK(link),
        .DISK_BIT(PAT[bi]), .DISK_BIT_TAKE(tk_raw), .FAULT_WRITE(flt[0]),
        .FAULT_SERVO(flt[1]), .FAULT_SPEED(flt[2]), .FAULT_POWER(flt[3]),
        .PROTECT_PLATTER(prot), .HIGH_DENSITY_FITTED(1'b1),
        .DUAL_PLATTER_FITTED(1'b1), .SEEK_START(sk), .SEEK_CYL(cyl),
        .HEAD_UNLOAD(unl), .NOT_READY(nrdy), .WRITE_ON(won), .ERASE_ON(eon));
    ddsh_ctl ddsh_ctl_inst (.CLK(CLK), .RESET_N(RESET_N), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hw), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq), .LINK(link));
    ddsh_assertions ddsh_assertions_inst (.CLK(CLK), .RESET_N(RESET_N),
        .strobe_n(link.strobe_n), .cyl_n(link.cyl_n),
        .read_clock_n(link.read_clock_n), .read_data_n(link.read_data_n),
        .seek_accept_pulse_n(link.seek_accept_pulse_n),
        .illegal_seek_pulse_n(link.illegal_seek_pulse_n),
        .fault_n(link.fault_n),
        .unused_positioner_fail_line_n(link.unused_positioner_fail_line_n));
    initial forever #20 CLK = ~CLK;
    // Outputs are sampled mid-cycle, where every register has settled.
    always @(negedge CLK) begin
        tk <= tk_raw;
        n_seek <= n_seek + int'(sk);
        n_unl <= n_unl + int'(unl);
    end
    // The next disk bit is offered once the drive has taken the current one.
    always @(posedge CLK) if (tk) bi <= bi - 3'h1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge CLK);
        htrans <= 2'h2;
        haddr <= a;
        hw <= w;
        do @(negedge CLK); while (hready !== 1'b1);
        @(posedge CLK);
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge CLK); while (hready !== 1'b1);
        q = hrdata;
        chk(hresp, 1'b0);
    endtask
    task automatic wirq;
        for (int i = 0; i < 1200 && irq !== 1'b1; i++) @(negedge CLK);
    endtask
    task automatic t_seek;
        logic [7:0] c [4] = '{8'h10, 8'h10, 8'hc7, 8'hc8};
        logic [7:0] e = 8'h00;
        int n = 0;
        foreach (c[i]) begin
            bus(1'b1, REG_SEEK, {24'h0, c[i]});
            wirq();
            bus(1'b0, REG_STAT, 0);
            chk(q, c[i] > MAX_CYL ? 32'h2 : 32'h1);
            if (c[i] <= MAX_CYL) n++;
            if (c[i] <= MAX_CYL) e = c[i];
            chk(n_seek, n);
            chk({24'h0, cyl}, {24'h0, e});
            if (i == 0) begin
                bus(1'b1, REG_MASK, 0);
                repeat (2) @(negedge CLK);
                chk(irq, 0);
                bus(1'b1, REG_MASK, 32'hf);
            end
            bus(1'b1, REG_STAT, 32'h3);
            repeat (200) @(negedge CLK);
            chk(irq, 0);
        end
        $display("seek test done");
    endtask
    task automatic t_read;
        bus(1'b1, REG_CTRL, 32'h5);
        wirq();
        bus(1'b0, REG_RXD, 0);
        chk(q, {24'h0, PAT});
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_STAT, 32'h8);
        $display("read test done");
    endtask
    task automatic t_prot;
        bus(1'b1, REG_CTRL, 32'h19);
        repeat (25) @(negedge CLK);
        chk(link.wr_status_n, 0);
        chk({won, eon}, 2'b00);
        bus(1'b1, REG_CTRL, 32'h1b);
        repeat (25) @(negedge CLK);
        chk(link.wr_status_n, 1);
        chk({won, eon}, 2'b11);
        $display("protect test done");
    endtask
    task automatic t_fault;
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            flt <= 4'h1 << i;
            repeat (10) @(posedge CLK);
            flt <= 4'h0;
            wirq();
            bus(1'b0, REG_STAT, 0);
            chk(q, 32'h4);
            chk(n_unl, i + 1);
            bus(1'b1, REG_STAT, 32'h4);
            repeat (150) @(negedge CLK);
        end
        chk({nrdy, won}, 2'b10);
        bus(1'b0, REG_LINE, 0);
        chk(q & 32'h16, 32'h6);
        bus(1'b0, 32'h20, 0);
        chk(q, 0);
        $display("fault test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        bus(1'b1, REG_MASK, 32'hf);
        t_seek();
        t_read();
        t_prot();
        t_fault();
        print_verdict();
    end
    // About six times the expected run, so a hang still ends the run.
    initial begin
        #(40 * 30000);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
